// ### inc/psl_pkg.sv
package psl_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int POS_W  = 32;
  localparam int VEL_W  = 24;
  localparam int GAIN_W = 16;
  localparam int ERR_W  = 24;
  localparam int DAC_W  = 16;
  localparam int ACC_W  = 40;
  localparam int PRD_W  = ERR_W + GAIN_W + 8;
  localparam int FRAC   = 8;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int SERVO_US     = 400;
  localparam int SERVO_CYCLES = (CLK_HZ / 1_000_000) * SERVO_US;
  localparam int TICK_W       = 14;

  // ------------------------------------------------------------------
  // Limits and reset values
  // ------------------------------------------------------------------
  localparam logic signed [DAC_W-1:0] DAC_MAX  = 16'sh7FFF;
  localparam logic signed [DAC_W-1:0] DAC_MIN  = -16'sh7FFF;
  localparam logic signed [ACC_W-1:0] INT_MAX  = 40'sh00_7FFF_0000;
  localparam logic signed [ACC_W-1:0] INT_MIN  = -40'sh00_7FFF_0000;
  localparam logic signed [GAIN_W-1:0] GAIN_RST = 16'sh0000;

  typedef struct packed {
    logic signed [GAIN_W-1:0] kp;
    logic signed [GAIN_W-1:0] ki;
    logic signed [GAIN_W-1:0] kd;
    logic signed [GAIN_W-1:0] kvff;
    logic signed [GAIN_W-1:0] kaff;
  } psl_gains_t;

  typedef struct packed {
    logic signed [POS_W-1:0] pos;
    logic signed [VEL_W-1:0] vel;
    logic signed [VEL_W-1:0] acc;
  } psl_traj_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ERR, ST_MUL, ST_SUM, ST_OUT
  } psl_state_t;

endpackage : psl_pkg

// ### logic/psl_mac.sv
`timescale 1ns/1ps
// Registered signed product with clock enable.
module psl_mac (
  input  wire logic                               i_ref_clk,
  input  wire logic                               i_reset,
  input  wire logic                               i_ce,
  input  wire logic signed [psl_pkg::ACC_W-1:0]  i_a,
  input  wire logic signed [psl_pkg::GAIN_W-1:0] i_b,
  output logic signed [psl_pkg::PRD_W-1:0]       o_p
);
  import psl_pkg::*;

  logic signed [ACC_W+GAIN_W-1:0] full;

  assign full = i_a * i_b;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_p <= '0;
    end else if (i_ce) begin
      o_p <= full[PRD_W-1:0];
    end
  end
endmodule : psl_mac

// ### logic/psl_servo.sv
`timescale 1ns/1ps
module psl_servo (
  input  wire logic                               i_ref_clk,
  input  wire logic                               i_reset,
  input  wire logic                               i_ce,
  input  wire logic                               i_enable,
  input  wire psl_pkg::psl_gains_t                i_gains,
  input  wire psl_pkg::psl_traj_t                 i_traj,
  input  wire logic signed [psl_pkg::POS_W-1:0]  i_enc_pos,
  output logic signed [psl_pkg::DAC_W-1:0]       o_dac_data,
  output logic                                    o_dac_load,
  output logic signed [psl_pkg::ERR_W-1:0]       o_follow_err,
  output logic                                    o_sat
);
  import psl_pkg::*;

  // ------------------------------------------------------------------
  // Servo tick
  // ------------------------------------------------------------------
  logic [TICK_W-1:0] tick_reg;
  logic              tick;

  assign tick = (tick_reg == TICK_W'(SERVO_CYCLES - 1));

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_reg <= '0;
    end else if (i_ce) begin
      tick_reg <= tick ? '0 : tick_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  psl_state_t state_reg;
  logic [2:0] term_reg;

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      term_reg  <= '0;
    end else if (i_ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (tick && i_enable) begin
            state_reg <= ST_ERR;
          end
        end
        ST_ERR: begin
          state_reg <= ST_MUL;
          term_reg  <= '0;
        end
        ST_MUL: begin
          term_reg <= term_reg + 1'b1;
          if (term_reg == 3'd5) begin
            state_reg <= ST_SUM;
          end
        end
        ST_SUM:  state_reg <= ST_OUT;
        ST_OUT:  state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Sampled inputs and error
  // ------------------------------------------------------------------
  psl_gains_t              gains_reg;
  psl_traj_t               traj_reg;
  logic signed [ERR_W-1:0] err_reg;
  logic signed [ERR_W-1:0] prev_err_reg;
  logic signed [POS_W:0]   diff;

  // Saturate the position difference so a large excursion cannot alias to a small error.
  function automatic logic signed [ERR_W-1:0] sat_err(input logic signed [POS_W:0] v);
    logic signed [POS_W:0] hi;
    logic signed [POS_W:0] lo;
    hi = (POS_W+1)'({1'b0, {(ERR_W-1){1'b1}}});
    lo = -hi;
    if (v > hi) begin
      sat_err = hi[ERR_W-1:0];
    end else if (v < lo) begin
      sat_err = lo[ERR_W-1:0];
    end else begin
      sat_err = v[ERR_W-1:0];
    end
  endfunction : sat_err

  assign diff = {traj_reg.pos[POS_W-1], traj_reg.pos} - {i_enc_pos[POS_W-1], i_enc_pos};

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      gains_reg <= '0;
      traj_reg  <= '0;
    end else if (i_ce && state_reg == ST_IDLE && tick && i_enable) begin
      gains_reg <= i_gains;
      traj_reg  <= i_traj;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      err_reg      <= '0;
      prev_err_reg <= '0;
    end else if (i_ce && state_reg == ST_ERR) begin
      prev_err_reg <= err_reg;
      err_reg      <= sat_err(diff);
    end
  end

  // ------------------------------------------------------------------
  // Integral accumulator
  // ------------------------------------------------------------------
  logic signed [ACC_W-1:0] int_reg;
  logic signed [ACC_W:0]   int_sum;

  function automatic logic signed [ACC_W-1:0] clamp_acc(input logic signed [ACC_W:0] v,
                                                        input logic signed [ACC_W-1:0] hi,
                                                        input logic signed [ACC_W-1:0] lo);
    // The limits are widened as signed values; an unsigned compare would clip every sign.
    if (v > $signed({hi[ACC_W-1], hi})) begin
      clamp_acc = hi;
    end else if (v < $signed({lo[ACC_W-1], lo})) begin
      clamp_acc = lo;
    end else begin
      clamp_acc = v[ACC_W-1:0];
    end
  endfunction : clamp_acc

  assign int_sum = {int_reg[ACC_W-1], int_reg} + (ACC_W+1)'(err_reg);

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      int_reg <= '0;
    end else if (i_ce) begin
      if (!i_enable) begin
        int_reg <= '0;
      end else if (state_reg == ST_MUL && term_reg == 3'd0) begin
        int_reg <= clamp_acc(int_sum, INT_MAX, INT_MIN);
      end
    end
  end

  // ------------------------------------------------------------------
  // Shared multiplier: one term per cycle
  // ------------------------------------------------------------------
  logic signed [ACC_W-1:0]  mul_a;
  logic signed [GAIN_W-1:0] mul_b;
  logic signed [PRD_W-1:0]  prod;

  // Sharing one multiplier costs six cycles of a 16000-cycle period; plenty of slack.
  always_comb begin
    mul_a = '0;
    mul_b = '0;
    case (term_reg)
      3'd1: begin
        mul_a = ACC_W'(err_reg);
        mul_b = gains_reg.kp;
      end
      3'd2: begin
        mul_a = int_reg;
        mul_b = gains_reg.ki;
      end
      3'd3: begin
        mul_a = ACC_W'(err_reg) - ACC_W'(prev_err_reg);
        mul_b = gains_reg.kd;
      end
      3'd4: begin
        mul_a = ACC_W'(traj_reg.vel);
        mul_b = gains_reg.kvff;
      end
      3'd5: begin
        mul_a = ACC_W'(traj_reg.acc);
        mul_b = gains_reg.kaff;
      end
      default: begin
        mul_a = '0;
        mul_b = '0;
      end
    endcase
  end

  psl_mac u_mac (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_a       (mul_a),
    .i_b       (mul_b),
    .o_p       (prod)
  );

  // ------------------------------------------------------------------
  // Summation and output
  // ------------------------------------------------------------------
  logic signed [PRD_W+3:0] sum_reg;
  logic signed [PRD_W+3:0] scaled;
  logic signed [DAC_W-1:0] out_val;
  logic                    out_sat;

  // The product appears one cycle after its term is selected.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sum_reg <= '0;
    end else if (i_ce) begin
      if (state_reg == ST_ERR) begin
        sum_reg <= '0;
      end else if ((state_reg == ST_MUL && term_reg >= 3'd2) || state_reg == ST_SUM) begin
        sum_reg <= sum_reg + (PRD_W+4)'(prod);
      end
    end
  end

  assign scaled = sum_reg >>> FRAC;

  always_comb begin
    out_sat = 1'b1;
    if (scaled > (PRD_W+4)'(DAC_MAX)) begin
      out_val = DAC_MAX;
    end else if (scaled < (PRD_W+4)'(DAC_MIN)) begin
      out_val = DAC_MIN;
    end else begin
      out_val = scaled[DAC_W-1:0];
      out_sat = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_dac_data   <= '0;
      o_dac_load   <= 1'b0;
      o_follow_err <= '0;
      o_sat        <= 1'b0;
    end else if (i_ce) begin
      o_dac_load <= 1'b0;
      if (!i_enable) begin
        o_dac_data <= '0;
      end else if (state_reg == ST_OUT) begin
        o_dac_data   <= out_val;
        o_dac_load   <= 1'b1;
        o_follow_err <= err_reg;
        o_sat        <= out_sat;
      end
    end
  end

endmodule : psl_servo

// ### verification/psl_servo_monitor.sv
`timescale 1ns/1ps
module psl_servo_monitor (
  input wire logic                              i_ref_clk,
  input wire logic                              i_reset,
  input wire logic                              i_ce,
  input wire logic                              i_enable,
  input wire logic signed [psl_pkg::DAC_W-1:0] o_dac_data,
  input wire logic                              o_dac_load,
  input wire logic signed [psl_pkg::ERR_W-1:0] o_follow_err,
  input wire logic                              o_sat
);
  import psl_pkg::*;
  logic [15:0] gap_reg;
  logic        seen_reg;
  logic [3:0]  off_reg;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= o_dac_load ? 16'h0000 : (i_ce ? gap_reg + 16'h0001 : gap_reg);
    end
  end
  // The period is only meaningful between two loads of one enabled run.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= i_enable & (seen_reg | o_dac_load);
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      off_reg <= '0;
    end else begin
      off_reg <= i_enable ? 4'h0 : (off_reg == 4'hF || !i_ce ? off_reg : off_reg + 4'h1);
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_pulse; o_dac_load && i_ce |=> !o_dac_load; endproperty
  a_pulse: assert property (p_pulse) else $error("load longer than one cycle");
  property p_period; o_dac_load && seen_reg |-> gap_reg == 16'(SERVO_CYCLES - 1); endproperty
  a_period: assert property (p_period) else $error("servo period wrong");
  property p_hold; i_enable && $past(i_enable) && !o_dac_load |-> $stable(o_dac_data); endproperty
  a_hold: assert property (p_hold) else $error("output changed without load");
  property p_err; !o_dac_load |-> $stable(o_follow_err); endproperty
  a_err: assert property (p_err) else $error("error changed without load");
  property p_sat; !o_dac_load |-> $stable(o_sat); endproperty
  a_sat: assert property (p_sat) else $error("clip flag changed without load");
  property p_clip; o_dac_load && o_sat |-> o_dac_data == DAC_MAX || o_dac_data == DAC_MIN; endproperty
  a_clip: assert property (p_clip) else $error("clipped value not full scale");
  property p_range; o_dac_data != 16'sh8000 && o_follow_err != 24'sh800000; endproperty
  a_range: assert property (p_range) else $error("value beyond full scale");
  property p_off; !i_enable && i_ce ##1 !i_enable ##1 !i_enable |-> o_dac_data == 16'sh0000; endproperty
  a_off: assert property (p_off) else $error("output not zero while disabled");
  property p_idle; off_reg > 4'hC |-> !o_dac_load; endproperty
  a_idle: assert property (p_idle) else $error("load while disabled");
endmodule : psl_servo_monitor
bind psl_servo psl_servo_monitor u_mon (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_ce(i_ce), .i_enable(i_enable), .o_dac_data(o_dac_data), .o_dac_load(o_dac_load),
  .o_follow_err(o_follow_err), .o_sat(o_sat));

// ### verification/psl_plant.sv
`timescale 1ns/1ps
module psl_plant (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_reset,
  input  wire logic signed [psl_pkg::DAC_W-1:0] i_drive,
  input  wire logic                              i_drive_load,
  output logic signed [psl_pkg::POS_W-1:0]      o_enc_pos
);
  import psl_pkg::*;
  // Position moves only after a new drive value, so it is steady during a computation.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_enc_pos <= 32'sh0000_0100;
    end else if (i_drive_load) begin
      o_enc_pos <= o_enc_pos + POS_W'(i_drive >>> 4);
    end
  end
endmodule : psl_plant

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import psl_pkg::*;
  logic                    i_ref_clk, i_reset, i_enable, ce, load, sat, got;
  psl_gains_t              i_gains, g;
  psl_traj_t               i_traj, t;
  logic signed [POS_W-1:0] enc;
  logic signed [DAC_W-1:0] dac;
  logic signed [ERR_W-1:0] ferr;
  logic [31:0]             lfsr;
  logic [79:0]             gv;
  int                      n_errors, checked;
  longint                  acc_i;
  longint                  err_q[$];
  psl_servo DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(ce), .i_enable(i_enable),
    .i_gains(i_gains), .i_traj(i_traj), .i_enc_pos(enc), .o_dac_data(dac),
    .o_dac_load(load), .o_follow_err(ferr), .o_sat(sat));
  psl_plant u_plant (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_drive(dac),
    .i_drive_load(load), .o_enc_pos(enc));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input longint exp, input logic signed [47:0] seen);
    checked++;
    if (seen !== exp[47:0]) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic new_inputs(input int k);
    for (int i = 0; i < 7; i++) begin
      lfsr = nxt(lfsr);
      // Small operands keep most results inside full scale, so the sum itself is seen.
      if (i < 5) gv[i*16 +: 16] = {{8{lfsr[7]}}, lfsr[7:0]};
      if (i == 5) t.vel = {{12{lfsr[11]}}, lfsr[11:0]};
      if (i == 6) t.acc = {{12{lfsr[11]}}, lfsr[11:0]};
    end
    g = gv;
    t.pos = (k == 2) ? 32'sh4000_0000 : {{20{lfsr[31]}}, lfsr[31:20]};
    i_gains <= g;
    i_traj <= t;
  endtask : new_inputs
  // --------------------------------------------------------------
  // Reference loop model with 64-bit integers
  // --------------------------------------------------------------
  task automatic expect_out();
    longint e, s, o, d;
    e = longint'(t.pos) - longint'(enc);
    e = e > 8388607 ? 8388607 : (e < -8388607 ? -8388607 : e);
    d = e - (err_q.size() > 0 ? err_q[$] : 0);
    err_q.push_back(e);
    acc_i += e;
    acc_i = acc_i > 2147418112 ? 2147418112 : (acc_i < -2147418112 ? -2147418112 : acc_i);
    s = g.kp * e + g.ki * acc_i + g.kd * d + g.kvff * t.vel + g.kaff * t.acc;
    s = s >>> 8;
    o = s > 32767 ? 32767 : (s < -32767 ? -32767 : s);
    chk("dac", o, dac);
    chk("err", e, ferr);
    chk("sat", longint'(s != o), sat);
  endtask : expect_out
  task automatic wait_load(input int k, input bit want);
    int c;
    int frz;
    frz = (k == 1) ? 50 : 0;
    got = 1'b0;
    c = 0;
    while (c < 16100 && !got) begin
      c++;
      @(posedge i_ref_clk);
      // Gains disturbed after capture must not reach this result.
      if (k > 0 && c == 15992 + frz) i_gains <= ~g;
      // A frozen clock enable must stretch the period by exactly its own length.
      if (frz > 0 && c == 100) ce <= 1'b0;
      if (frz > 0 && c == 100 + frz) ce <= 1'b1;
      got = load;
    end
    chk("load", want, got);
    if (got && want) chk("load_cycle", SERVO_CYCLES + (k == 0 ? 10 : frz), c);
    if (got !== want) report_and_stop();
  endtask : wait_load
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_reset = 1'b1;
    i_enable = 1'b1;
    i_gains = '0;
    i_traj = '0;
    lfsr = 32'hF1B1F6FD;
    ce = 1'b1;
    n_errors = 0;
    checked = 0;
    acc_i = 0;
    repeat (20) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    new_inputs(0);
    for (int k = 0; k < 4; k++) begin
      wait_load(k, 1'b1);
      expect_out();
      new_inputs(k + 1);
    end
    i_enable <= 1'b0;
    wait_load(0, 1'b0);
    chk("dac_off", 0, dac);
    report_and_stop();
  end
endmodule : tb
